/* File: hdl/mcu_interrupt_logic.sv */
// How it works
// - Ten sources: pin edge, timer, port change and seven peripheral events.
// - Global enable bit 7 passes unmasked requests; cleared it blocks all.
// - Every reset clears the global enable.
// - Return from service routine sets the global enable again.
// - Taking an interrupt clears global enable, pushes PC, jumps to 0004h.
// - Source flags set on their event regardless of any enable.
// - Jump comes three cycles after sync events, three to four async.
// - Latency does not depend on one or two cycle instructions.
// - After software clears global enable, a NOP cycle; requests stay pending.
// - Pin edge polarity follows the option register edge select bit 6.
// - Valid pin edge sets control bit 1; bit 4 enables it.
// - Pin event wakes from sleep if enabled; global enable decides the jump.
// - Timer roll-over FFh to 00h sets bit 2; bit 5 enables it.
// - Change on port bits 7..4 sets bit 0; enable at bit 3.
// - A port change during a Q2 read may not set the flag.
// - Pin flag sampled every Q1, may be set during Q4 to Q1.
// - Peripheral flags and enables sit in separate registers, same bits.
// - Only the return PC is saved on entry.
module mcu_interrupt_logic
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt sources
  input  wire logic        ext_irq_pin_i,
  input  wire logic [7:0]  timer_zero_count_i,
  input  wire logic [3:0]  port_upper_i,
  input  wire logic        port_read_i,
  input  wire logic [7:0]  periph_event_i,
  // Processor core
  input  wire logic        return_from_isr_i,
  input  wire logic        sleep_i,
  output logic [1:0]       q_phase_o,
  output logic             irq_pending_o,
  output logic             vector_jump_o,
  output logic             push_pc_o,
  output logic [12:0]      pc_vector_o,
  output logic             force_nop_o,
  output logic             wake_o
);

  logic       rst_s1_reg;
  logic       rst_n;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] pflag_reg;
  logic [7:0] pflag_next;
  logic [7:0] pen_reg;
  logic       edge_sel_reg;
  phase_e     phase_reg;
  lat_state_e state_reg;
  logic [3:0] lat_cnt_reg;
  logic [2:0] nop_cnt_reg;
  logic       ack_reg;
  logic [31:0] rdat_reg;
  logic       pin_s1_reg;
  logic       pin_s2_reg;
  logic       pin_prev_reg;
  logic       ext_hold_reg;
  logic [3:0] port_s1_reg;
  logic [3:0] port_s2_reg;
  logic [3:0] port_latch_reg;
  logic [7:0] tmr_prev_reg;
  logic [7:0] idx;
  logic       bus_req;
  logic       wr_en;
  logic       gie_clr_wr;
  logic       pin_edge;
  logic       ext_set;
  logic       tmr_roll;
  logic       port_set;
  logic       any_pair;
  logic       take_irq;

  // Reset is asserted at once but released through two flops.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  function automatic logic pair_active(input logic [7:0] c,
                                       input logic [7:0] pf,
                                       input logic [7:0] pe);
    logic core_pair;
    logic peri_pair;
    core_pair = |(c[B_TOE:B_PCE] & c[B_TOF:B_PCF]);
    peri_pair = c[B_PERIPHERAL_GROUP_ENABLE] & |(pf & pe & PERI_MASK);
    return core_pair | peri_pair;
  endfunction

  assign idx     = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];
  assign gie_clr_wr = wr_en && (idx == IDX_CTRL) &&
                      ctrl_reg[B_GIE] && !wb_dat_i[B_GIE];
  assign any_pair = pair_active(ctrl_reg, pflag_reg, pen_reg);
  assign take_irq = (state_reg == ST_WAIT) &&
                    (lat_cnt_reg == 4'h0) && ctrl_reg[B_GIE];

  // Q phase sequencer: one instruction cycle is four clocks.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= Q1_PH;
    end else begin
      phase_reg <= phase_e'(phase_reg + 2'h1);
    end
  end

  // Pin synchroniser; the edge is held until a Q4 or Q1 phase.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_prev_reg <= 1'b0;
      ext_hold_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= ext_irq_pin_i;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      if (ext_set) begin
        ext_hold_reg <= 1'b0;
      end else if (pin_edge) begin
        ext_hold_reg <= 1'b1;
      end
    end
  end

  assign pin_edge = edge_sel_reg ? (pin_s2_reg & ~pin_prev_reg)
                                 : (~pin_s2_reg & pin_prev_reg);
  assign ext_set = (pin_edge | ext_hold_reg) &&
                   (phase_reg == Q4_PH || phase_reg == Q1_PH);

  // Port change detection against the value last read.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port_s1_reg    <= 4'h0;
      port_s2_reg    <= 4'h0;
      port_latch_reg <= 4'h0;
      tmr_prev_reg   <= TMR_ZERO;
    end else begin
      port_s1_reg  <= port_upper_i;
      port_s2_reg  <= port_s1_reg;
      tmr_prev_reg <= timer_zero_count_i;
      if (port_read_i) begin
        port_latch_reg <= port_s2_reg;
      end
    end
  end

  // A read in Q2 refreshes the latch and swallows a coincident change.
  assign port_set = (port_s2_reg != port_latch_reg) &&
                    !(port_read_i && phase_reg == Q2_PH);
  assign tmr_roll = (tmr_prev_reg == TMR_TOP) &&
                    (timer_zero_count_i == TMR_ZERO);

  // Hardware sets win over a software clear in the same cycle.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_en && idx == IDX_CTRL) begin
      ctrl_next = wb_dat_i[7:0];
    end
    if (return_from_isr_i) begin
      ctrl_next[B_GIE] = 1'b1;
    end
    if (take_irq) begin
      ctrl_next[B_GIE] = 1'b0;
    end
    ctrl_next[B_EXF] = ctrl_next[B_EXF] | ext_set;
    ctrl_next[B_TOF] = ctrl_next[B_TOF] | tmr_roll;
    ctrl_next[B_PCF] = ctrl_next[B_PCF] | port_set;
  end

  always_comb begin
    pflag_next = pflag_reg;
    if (wr_en && idx == IDX_PFLAG) begin
      pflag_next = wb_dat_i[7:0] & PERI_MASK;
    end
    pflag_next = pflag_next | (periph_event_i & PERI_MASK);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pflag_reg    <= PERI_RST;
      pen_reg      <= PERI_RST;
      edge_sel_reg <= EDGE_RST;
    end else begin
      pflag_reg <= pflag_next;
      if (wr_en && idx == IDX_PEN) begin
        pen_reg <= wb_dat_i[7:0] & PERI_MASK;
      end
      if (wr_en && idx == IDX_OPTION) begin
        edge_sel_reg <= wb_dat_i[B_EDGE];
      end
    end
  end

  // Latency counter: the request is sampled at Q1 and the jump lands
  // on a Q1 three instruction cycles later. It runs on the Q phases
  // only, so the length of the current instruction does not matter.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      lat_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (phase_reg == Q1_PH && ctrl_reg[B_GIE] &&
              any_pair && !force_nop_o) begin
            state_reg   <= ST_WAIT;
            lat_cnt_reg <= LAT_LOAD;
          end
        end
        ST_WAIT: begin
          if (!ctrl_reg[B_GIE] || lat_cnt_reg == 4'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            lat_cnt_reg <= lat_cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Entry pushes only the return PC; W and status stay with software.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vector_jump_o <= 1'b0;
      push_pc_o     <= 1'b0;
      pc_vector_o   <= IRQ_VECTOR;
    end else begin
      vector_jump_o <= take_irq;
      push_pc_o     <= take_irq;
      pc_vector_o   <= IRQ_VECTOR;
    end
  end

  // NOP window after software clears the global enable.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      nop_cnt_reg <= 3'h0;
      force_nop_o <= 1'b0;
    end else begin
      if (gie_clr_wr) begin
        nop_cnt_reg <= NOP_LOAD;
      end else if (nop_cnt_reg != 3'h0) begin
        nop_cnt_reg <= nop_cnt_reg - 3'h1;
      end
      force_nop_o <= gie_clr_wr || (nop_cnt_reg > 3'h1);
    end
  end

  // Wake ignores the global enable; the core decides the branch.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_o        <= 1'b0;
      irq_pending_o <= 1'b0;
      q_phase_o     <= Q1_PH;
    end else begin
      wake_o        <= sleep_i && any_pair;
      irq_pending_o <= ctrl_reg[B_GIE] && any_pair;
      q_phase_o     <= phase_e'(phase_reg + 2'h1);
    end
  end

  // Wishbone: one wait state, unmapped reads return zero.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        case (idx)
          IDX_CTRL:   rdat_reg <= {24'h000000, ctrl_reg};
          IDX_PFLAG:  rdat_reg <= {24'h000000, pflag_reg};
          IDX_PEN:    rdat_reg <= {24'h000000, pen_reg};
          IDX_OPTION: rdat_reg <= {24'h000000, 1'b0,
                                   edge_sel_reg, 6'h00};
          default:    rdat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Checks.
  sequence req_seen_s;
    state_reg == ST_IDLE && phase_reg == Q1_PH &&
    ctrl_reg[B_GIE] && any_pair && !force_nop_o;
  endsequence

  sequence gie_held_s;
    ctrl_reg[B_GIE][*8] ##1 ctrl_reg[B_GIE][*3];
  endsequence

  reset_gie_a: assert property (
    @(posedge clk_i) $rose(rst_n) |-> !ctrl_reg[B_GIE])
    else $error("global enable set after reset");

  latency_exact_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    req_seen_s ##1 gie_held_s |=> vector_jump_o)
    else $error("vector jump not three cycles after request");

  jump_entry_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    vector_jump_o |-> push_pc_o && !ctrl_reg[B_GIE] &&
                      pc_vector_o == IRQ_VECTOR && phase_reg == Q1_PH)
    else $error("bad interrupt entry");

  return_from_isr_sets_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    return_from_isr_i && !take_irq |=> ctrl_reg[B_GIE])
    else $error("return did not set global enable");

  timer_flag_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    tmr_roll |=> ctrl_reg[B_TOF])
    else $error("timer roll-over lost");

  pin_phase_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    $rose(ctrl_reg[B_EXF]) |-> phase_reg == Q1_PH ||
                               phase_reg == Q2_PH)
    else $error("pin flag set outside Q4 to Q1");

  nop_window_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    gie_clr_wr |=> force_nop_o[*4] ##0 !vector_jump_o)
    else $error("no NOP cycle after enable clear");

  periph_flag_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    periph_event_i[0] |=> pflag_reg[0])
    else $error("peripheral event lost");

  wake_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    sleep_i && any_pair |=> wake_o)
    else $error("no wake on pending pair");

  no_gie_jump_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !ctrl_reg[B_GIE] |=> !vector_jump_o)
    else $error("jump with global enable clear");

endmodule // mcu_interrupt_logic

/* File: include/irq_pkg.sv */
package irq_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_CTRL   = 8'h0B;
  localparam logic [7:0] IDX_PFLAG  = 8'h0C;
  localparam logic [7:0] IDX_PEN    = 8'h8C;
  localparam logic [7:0] IDX_OPTION = 8'h81;

  // Bit positions in interrupt_main_control.
  localparam int B_GIE  = 7;
  localparam int B_PERIPHERAL_GROUP_ENABLE = 6;
  localparam int B_TOE  = 5;
  localparam int B_EXE  = 4;
  localparam int B_PCE  = 3;
  localparam int B_TOF  = 2;
  localparam int B_EXF  = 1;
  localparam int B_PCF  = 0;
  // Edge select position in the option register.
  localparam int B_EDGE = 6;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PERI_RST = 8'h00;
  localparam logic       EDGE_RST = 1'b1;
  // Bit 3 of the peripheral pair is unimplemented.
  localparam logic [7:0] PERI_MASK = 8'hF7;

  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [7:0]  TMR_TOP    = 8'hFF;
  localparam logic [7:0]  TMR_ZERO   = 8'h00;

  // Timing: four Q phases per instruction cycle at 20 MHz.
  localparam int CLK_HZ      = 20_000_000;
  localparam int TCY_CLKS    = 4;
  localparam int LAT_TCY     = 3;
  localparam int LAT_CLKS    = LAT_TCY * TCY_CLKS;
  localparam logic [3:0] LAT_LOAD = 4'(LAT_CLKS - 2);
  localparam logic [2:0] NOP_LOAD = 3'(TCY_CLKS);

  typedef enum logic [1:0] {
    Q1_PH = 2'b00,
    Q2_PH = 2'b01,
    Q3_PH = 2'b10,
    Q4_PH = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } lat_state_e;

endpackage

/* File: verification/core_model.sv */
module core_model
  import irq_pkg::*;
(
  // Clock and bench request
  input  wire logic        clk_i,
  input  wire logic        ret_go_i,
  // Interrupt outputs of the block
  input  wire logic        jump_i,
  input  wire logic        push_i,
  input  wire logic [12:0] vec_i,
  input  wire logic [1:0]  phase_i,
  // Core answers
  output logic             ret_o,
  output logic [7:0]       jumps_o,
  output logic             bad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ret_o = 1'b0;
    jumps_o = 8'h00;
    bad_o = 1'b0;
  end
  // The core stacks only the return address; no other state is saved.
  always @(posedge clk_i) begin
    ret_o <= ret_go_i;
    if (jump_i === 1'b1) begin
      jumps_o <= jumps_o + 8'h01;
      if (push_i !== 1'b1 || vec_i !== IRQ_VECTOR) bad_o <= 1'b1;
      if (phase_i !== Q1_PH) bad_o <= 1'b1;
    end else if (push_i === 1'b1) begin
      bad_o <= 1'b1;
    end
  end
endmodule // core_model

/* File: verification/tb_top.sv */
module tb_top;
  import irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] CA = {IDX_CTRL, 2'b00};
  localparam logic [9:0] FA = {IDX_PFLAG, 2'b00};
  localparam logic [9:0] EA = {IDX_PEN, 2'b00};
  localparam logic [9:0] OA = {IDX_OPTION, 2'b00};
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic        pin = 1'b0;
  logic [7:0]  tmr = 8'h00;
  logic [3:0]  port = 4'h0;
  logic [7:0]  pev = 8'h00;
  logic        sleep = 1'b0;
  logic        ret_go = 1'b0;
  logic        prd = 1'b0;
  logic [31:0] rdat;
  logic        ack, ret, bad, jump, push, nop, wake, pend;
  logic [1:0]  qph;
  logic [12:0] vec;
  logic [7:0]  jumps;
  logic [7:0]  r;
  logic [7:0]  expq[$];
  int          miscompares = 0;
  int          check_count = 0;
  int          n;
  integer      seed = 32'hAE3C15A2;

  always #25 clk_i = ~clk_i;

  mcu_interrupt_logic dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq_pin_i(pin), .timer_zero_count_i(tmr), .port_upper_i(port),
    .port_read_i(prd), .periph_event_i(pev), .return_from_isr_i(ret),
    .sleep_i(sleep), .q_phase_o(qph), .irq_pending_o(pend),
    .vector_jump_o(jump), .push_pc_o(push), .pc_vector_o(vec),
    .force_nop_o(nop), .wake_o(wake));
  core_model u_core (.clk_i(clk_i), .ret_go_i(ret_go), .jump_i(jump),
    .push_i(push), .vec_i(vec), .phase_i(qph), .ret_o(ret),
    .jumps_o(jumps), .bad_o(bad));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic timeout;
    miscompares++;
    $display("wrong value at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // Ack is sampled before the edge updates land, so no race with the slave.
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 20) timeout();
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus(a, 1'b0, 8'h00);
  endtask
  // Move the pin in Q2 so the synchronised edge lands in the Q4-Q1 window.
  task automatic edge_pin(input logic v);
    int k;
    k = 0;
    while (qph !== Q2_PH && k < 8) begin
      @(posedge clk_i);
      k++;
    end
    pin <= v;
    tick(10);
  endtask
  // Flip a port bit so that its synchronised value meets a one-cycle read
  // pulse in phase ph; the read also refreshes the change latch.
  task automatic port_hit(input logic [1:0] ph);
    int k;
    k = 0;
    while (qph !== 2'(ph + 2'h1) && k < 8) begin
      @(posedge clk_i);
      k++;
    end
    port <= port ^ 4'h2;
    tick(2);
    prd <= 1'b1;
    tick(1);
    prd <= 1'b0;
    tick(2);
  endtask
  task automatic roll;
    @(posedge clk_i);
    tmr <= TMR_TOP;
    @(posedge clk_i);
    tmr <= TMR_ZERO;
  endtask
  task automatic wait_jump;
    n = 0;
    while (jump !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) timeout();
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      check(rdat[7:0], expq.pop_front());
    end
  end

  initial begin
    tick(5);
    rst_n_i <= 1'b1;
    tick(3);
    rd(CA, CTRL_RST);
    rd(FA, PERI_RST);
    rd(EA, PERI_RST);
    rd(OA, 8'h40);
    rd(10'h3FC, 8'h00);
    $display("test reset values done");
    r = 8'($random(seed));
    wr(EA, r);
    rd(EA, r & PERI_MASK);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      pev <= 8'h01 << i;
      @(posedge clk_i);
      pev <= 8'h00;
      rd(FA, PERI_MASK & ((8'h02 << i) - 8'h01));
    end
    check({7'h00, pend}, 8'h00);
    wr(FA, 8'h00);
    rd(FA, 8'h00);
    $display("test peripheral flags done");
    wr(CA, 8'h10);
    edge_pin(1'b1);
    rd(CA, 8'h12);
    sleep <= 1'b1;
    tick(3);
    check({7'h00, wake}, 8'h01);
    check(jumps, 8'h00);
    sleep <= 1'b0;
    wr(CA, 8'h10);
    wr(OA, 8'h00);
    edge_pin(1'b0);
    rd(CA, 8'h12);
    wr(CA, 8'h10);
    edge_pin(1'b1);
    rd(CA, 8'h10);
    $display("test pin edge done");
    wr(CA, 8'h08);
    r = 8'($random(seed)) | 8'h01;
    port <= port ^ r[3:0];
    tick(10);
    rd(CA, 8'h09);
    sleep <= 1'b1;
    tick(3);
    check({7'h00, wake}, 8'h01);
    sleep <= 1'b0;
    port_hit(Q1_PH);
    wr(CA, 8'h08);
    rd(CA, 8'h08);
    port_hit(Q2_PH);
    rd(CA, 8'h08);
    $display("test port change done");
    wr(CA, 8'h20);
    roll();
    tick(20);
    check(jumps, 8'h00);
    rd(CA, 8'h24);
    wr(CA, 8'hA4);
    wait_jump();
    rd(CA, 8'h24);
    wr(CA, 8'h20);
    @(posedge clk_i);
    ret_go <= 1'b1;
    @(posedge clk_i);
    ret_go <= 1'b0;
    tick(2);
    rd(CA, 8'hA0);
    roll();
    wait_jump();
    check({7'h00, n >= 14 && n <= 19}, 8'h01);
    rd(CA, 8'h24);
    wr(CA, 8'h20);
    wr(CA, 8'hA0);
    wr(CA, 8'h20);
    check({7'h00, nop}, 8'h01);
    tick(8);
    check(jumps, 8'h02);
    check({7'h00, bad}, 8'h00);
    $display("test timer interrupt done");
    // Park the pins at the levels the edge and change detectors reset to.
    pin <= 1'b0;
    port <= 4'h0;
    wr(CA, 8'hA0);
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    tick(3);
    rd(CA, CTRL_RST);
    rd(OA, 8'h40);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule // tb_top
